// ---- clk_sw_consts.svh ----
`ifndef CLK_SW_CONSTS_SVH
`define CLK_SW_CONSTS_SVH

// Register byte offsets
`define OFF_MODE 12'h000
`define OFF_STSEL 12'h004
`define OFF_RUN 12'h008
`define OFF_STSTAT 12'h00C
`define OFF_SYS 12'h010
`define OFF_SUB 12'h014

// Field positions
`define B_EXT 7
`define B_PINOSC 6
`define B_GAIN 0
`define B_XHALT 7
`define B_RUN_ONE 6
`define B_MIDEN 1
`define B_HHALT 0
`define B_CPU_STS 7
`define B_CPU_SEL 6
`define B_MAIN_STS 5
`define B_MAIN_SEL 4
`define B_OCH_STS 1
`define B_OCH_SEL 0
`define B_LOWEN 0

// Reset values
`define RST_STSEL 3'h7
`define RST_XHALT 1'b1

// Clock and oscillator start times
`define PCLK_NS 8
`define HIGH_START_NS 65000
`define MID_START_NS 4000
`define LOW_START_NS 210000
`define CYC(ns) (((ns) + `PCLK_NS - 1) / `PCLK_NS)

`endif

// ---- clk_sw_pkg.sv ----
package clk_sw_pkg;

  typedef enum logic [1:0] {
    SRC_HIGH,
    SRC_MID,
    SRC_LOW,
    SRC_SYS
  } src_t;

  typedef struct packed {
    logic crystal_drive;
    logic ext_clk_in;
    logic high_gain;
    logic high_osc_run;
    logic mid_osc_run;
    logic low_osc_run;
    src_t active_src;
  } osc_ctrl_t;

  typedef struct packed {
    logic ext_clk;
    logic pin_osc;
    logic high_gain;
    logic [2:0] stab_sel;
    logic crystal_halt;
    logic mid_en;
    logic high_halt;
    logic main_sel;
    logic main_sts;
    logic onchip_sel;
    logic onchip_sts;
    logic cpu_sel;
    logic cpu_sts;
    logic low_en;
    logic xin_s1;
    logic xin_s2;
    logic xin_s3;
    logic [18:0] xcnt;
    logic [15:0] high_cnt;
    logic [15:0] mid_cnt;
    logic [15:0] low_cnt;
    logic [31:0] rdata;
  } state_t;

endpackage : clk_sw_pkg

// ---- cpu_clock_source_switcher.sv ----
// Overview of operation
// - Oscillator mode bit 6 puts the crystal pins into oscillator operation.
// - Bit 7 with bit 6 takes an external clock instead of driving a crystal.
// - Stabilization select bits 2..0 set crystal wait; 010 is 102us at 10 MHz.
// - Clearing crystal halt bit 7 starts the crystal; external clock applied first.
// - Status flags bit 7..0 mark 2^8 through 2^18 crystal counts elapsed.
// - System control bit 4 selects the high-speed system clock as main clock.
// - System control bit 5 reads 1 once main clock really switched.
// - Run control bit 0 set stops the high on-chip oscillator.
// - System control bit 0 picks high (0) or middle (1) on-chip oscillator.
// - System control bit 1 shows the on-chip oscillator really in use.
// - Run control bit 1 set enables the middle on-chip oscillator.
// - Subsystem select bit 0 starts the low on-chip oscillator.
// - System control bit 6 selects subsystem clock as CPU clock.
// - System control bit 7 reads 1 once CPU really runs from subsystem clock.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "clk_sw_consts.svh"

module cpu_clock_source_switcher #(
  parameter logic [15:0] HIGH_START_CYC = 16'(`CYC(`HIGH_START_NS)),
  parameter logic [15:0] LOW_START_CYC = 16'(`CYC(`LOW_START_NS))
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xtal_in,
  output var clk_sw_pkg::osc_ctrl_t osc_ctrl
);
  import clk_sw_pkg::*;

  localparam logic [15:0] MID_START_CYC = 16'(`CYC(`MID_START_NS));

  state_t s_q;
  state_t s_d;

  // Any other offset answers with an error and leaves the registers alone
  function automatic logic mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      `OFF_MODE, `OFF_STSEL, `OFF_RUN: begin
        hit = 1'b1;
      end
      `OFF_STSTAT, `OFF_SYS, `OFF_SUB: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : mapped

  // Saturating start-up counter of an on-chip oscillator
  function automatic logic [15:0] osc_step(input logic en, input logic [15:0] c,
                                           input logic [15:0] lim);
    if (!en) begin
      return 16'h0000;
    end
    return (c < lim) ? c + 16'h0001 : c;
  endfunction : osc_step

  // Count limit of each stabilization select code
  function automatic logic [18:0] stab_limit(input logic [2:0] sel);
    case (sel)
      3'h0: begin
        return 19'h00100;
      end
      3'h1: begin
        return 19'h00200;
      end
      3'h2: begin
        return 19'h00400;
      end
      3'h3: begin
        return 19'h00800;
      end
      3'h4: begin
        return 19'h02000;
      end
      3'h5: begin
        return 19'h08000;
      end
      3'h6: begin
        return 19'h20000;
      end
      default: begin
        return 19'h40000;
      end
    endcase
  endfunction : stab_limit

  function automatic logic [7:0] stab_flags(input logic [18:0] c);
    logic [7:0] f;
    f = 8'h00;
    for (int i = 0; i < 8; i++) begin
      f[7 - i] = c >= stab_limit(3'(i));
    end
    return f;
  endfunction : stab_flags

  // Byte image of a register as software reads it; status bits are read-only copies
  function automatic logic [7:0] reg_image(input state_t s, input logic [11:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `OFF_MODE: begin
        v[`B_EXT] = s.ext_clk;
        v[`B_PINOSC] = s.pin_osc;
        v[`B_GAIN] = s.high_gain;
      end
      `OFF_STSEL: begin
        v[2:0] = s.stab_sel;
      end
      `OFF_RUN: begin
        v[`B_XHALT] = s.crystal_halt;
        v[`B_RUN_ONE] = 1'b1;
        v[`B_MIDEN] = s.mid_en;
        v[`B_HHALT] = s.high_halt;
      end
      `OFF_STSTAT: begin
        v = stab_flags(s.xcnt);
      end
      `OFF_SYS: begin
        v[`B_CPU_STS] = s.cpu_sts;
        v[`B_CPU_SEL] = s.cpu_sel;
        v[`B_MAIN_STS] = s.main_sts;
        v[`B_MAIN_SEL] = s.main_sel;
        v[`B_OCH_STS] = s.onchip_sts;
        v[`B_OCH_SEL] = s.onchip_sel;
      end
      `OFF_SUB: begin
        v[`B_LOWEN] = s.low_en;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : reg_image

  logic acc;
  logic setup;
  logic high_rdy;
  logic mid_rdy;
  logic low_rdy;
  logic sys_rdy;
  logic onchip_rdy;
  logic main_rdy;
  logic xin_rise;
  logic onchip_go;
  logic main_go;
  logic cpu_go;
  logic [7:0] wb;

  always_comb begin
    s_d = s_q;
    setup = psel && !penable;
    acc = psel && penable;
    wb = pwdata[7:0];

    high_rdy = s_q.high_cnt >= HIGH_START_CYC;
    mid_rdy = s_q.mid_cnt >= MID_START_CYC;
    low_rdy = s_q.low_cnt >= LOW_START_CYC;
    // External clock needs no wait; crystal waits for the selected count
    sys_rdy = s_q.pin_osc && !s_q.crystal_halt &&
              (s_q.ext_clk || s_q.xcnt >= stab_limit(s_q.stab_sel));
    onchip_rdy = s_q.onchip_sts ? mid_rdy : high_rdy;
    main_rdy = s_q.main_sts ? sys_rdy : onchip_rdy;

    // Pin synchroniser; stages two and three feed the edge detect
    s_d.xin_s1 = xtal_in;
    s_d.xin_s2 = s_q.xin_s1;
    s_d.xin_s3 = s_q.xin_s2;
    xin_rise = s_q.xin_s2 && !s_q.xin_s3;

    // Crystal counts only while the pins oscillate; a stop clears every flag
    if (!s_q.pin_osc || s_q.crystal_halt) begin
      s_d.xcnt = 19'h00000;
    end else if (xin_rise && s_q.xcnt < 19'h40000) begin
      s_d.xcnt = s_q.xcnt + 19'h00001;
    end

    s_d.high_cnt = osc_step(!s_q.high_halt, s_q.high_cnt, HIGH_START_CYC);
    s_d.mid_cnt = osc_step(s_q.mid_en, s_q.mid_cnt, MID_START_CYC);
    s_d.low_cnt = osc_step(s_q.low_en, s_q.low_cnt, LOW_START_CYC);

    // Status follows select only when the target source runs
    onchip_go = s_q.onchip_sel != s_q.onchip_sts && (s_q.onchip_sel ? mid_rdy : high_rdy);
    main_go = s_q.main_sel != s_q.main_sts && (s_q.main_sel ? sys_rdy : onchip_rdy);
    cpu_go = s_q.cpu_sel != s_q.cpu_sts && (s_q.cpu_sel ? low_rdy : main_rdy);
    if (onchip_go) begin
      s_d.onchip_sts = s_q.onchip_sel;
    end
    if (main_go) begin
      s_d.main_sts = s_q.main_sel;
    end
    if (cpu_go) begin
      s_d.cpu_sts = s_q.cpu_sel;
    end

    // Read data is captured in the setup cycle, so no wait states
    if (setup && !pwrite) begin
      s_d.rdata = {24'h000000, reg_image(s_q, paddr)};
    end

    if (acc && pwrite) begin
      case (paddr)
        `OFF_MODE: begin
          s_d.ext_clk = wb[`B_EXT];
          s_d.pin_osc = wb[`B_PINOSC];
          s_d.high_gain = wb[`B_GAIN];
        end
        `OFF_STSEL: begin
          s_d.stab_sel = wb[2:0];
        end
        `OFF_RUN: begin
          s_d.crystal_halt = wb[`B_XHALT];
          s_d.mid_en = wb[`B_MIDEN];
          s_d.high_halt = wb[`B_HHALT];
        end
        `OFF_SYS: begin
          s_d.cpu_sel = wb[`B_CPU_SEL];
          // Main select is frozen while the CPU runs on the subsystem clock
          if (!s_q.cpu_sts) begin
            s_d.main_sel = wb[`B_MAIN_SEL];
          end
          s_d.onchip_sel = wb[`B_OCH_SEL];
        end
        `OFF_SUB: begin
          s_d.low_en = wb[`B_LOWEN];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.stab_sel <= `RST_STSEL;
      s_q.crystal_halt <= `RST_XHALT;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped(paddr);

  always_comb begin
    osc_ctrl.crystal_drive = s_q.pin_osc && !s_q.ext_clk && !s_q.crystal_halt;
    osc_ctrl.ext_clk_in = s_q.pin_osc && s_q.ext_clk;
    osc_ctrl.high_gain = s_q.high_gain;
    osc_ctrl.high_osc_run = !s_q.high_halt;
    osc_ctrl.mid_osc_run = s_q.mid_en;
    osc_ctrl.low_osc_run = s_q.low_en;
    if (s_q.cpu_sts) begin
      osc_ctrl.active_src = SRC_LOW;
    end else if (s_q.main_sts) begin
      osc_ctrl.active_src = SRC_SYS;
    end else if (s_q.onchip_sts) begin
      osc_ctrl.active_src = SRC_MID;
    end else begin
      osc_ctrl.active_src = SRC_HIGH;
    end
  end

endmodule : cpu_clock_source_switcher
`default_nettype wire

// ---- clk_sw_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module clk_sw_monitor #(
  parameter logic [15:0] HIGH_START_CYC = 16'h0014,
  parameter logic [15:0] LOW_START_CYC = 16'h001E
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic xtal_in,
  input wire clk_sw_pkg::osc_ctrl_t osc_ctrl
);
  import clk_sw_pkg::*;
  logic wr;
  logic rd_stat;
  logic [7:0] nf;
  assign wr = psel && penable && pwrite;
  assign rd_stat = psel && !penable && !pwrite && paddr == 12'h00C;
  // Inverted flags: a thermometer code leaves a run of low-order ones
  assign nf = ~prdata[7:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HIGH_RUN: assert property (wr && paddr == 12'h008 |=> osc_ctrl.high_osc_run == !$past(pwdata[0]))
    else $error("high osc run wrong");
  AST_MID_RUN: assert property (wr && paddr == 12'h008 |=> osc_ctrl.mid_osc_run == $past(pwdata[1]))
    else $error("mid osc run wrong");
  AST_LOW_RUN: assert property (wr && paddr == 12'h014 |=> osc_ctrl.low_osc_run == $past(pwdata[0]))
    else $error("low osc run wrong");
  AST_EXT_MODE: assert property (wr && paddr == 12'h000 |=> osc_ctrl.ext_clk_in == ($past(pwdata[7:6]) == 2'h3))
    else $error("external mode wrong");
  AST_MID_STS: assert property ($changed(osc_ctrl.active_src) && osc_ctrl.active_src == SRC_MID |->
    $past(osc_ctrl.mid_osc_run)) else $error("mid status without osc");
  AST_LOW_STS: assert property ($changed(osc_ctrl.active_src) && osc_ctrl.active_src == SRC_LOW |->
    $past(osc_ctrl.low_osc_run)) else $error("low status without osc");
  AST_NO_EARLY: assert property (wr && paddr == 12'h010 |=> $stable(osc_ctrl.active_src))
    else $error("status moved on write");
  AST_THERMO: assert property (rd_stat |=> (nf & (nf + 8'h01)) == 8'h00)
    else $error("flags not cumulative");
endmodule : clk_sw_monitor
bind cpu_clock_source_switcher clk_sw_monitor #(.HIGH_START_CYC(HIGH_START_CYC), .LOW_START_CYC(LOW_START_CYC))
  clk_sw_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_in(xtal_in),
  .osc_ctrl(osc_ctrl));
`default_nettype wire

// ---- xtal_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module xtal_model (
  input wire logic pclk,
  input wire logic run,
  output logic xtal_in
);
  logic [1:0] div_q;
  initial div_q = 2'h0;
  initial xtal_in = 1'h0;
  // Stands still while stopped, so a halted pin shows no edges
  always @(posedge pclk) begin
    div_q <= (run && div_q != 2'h2) ? div_q + 2'h1 : 2'h0;
    if (run && div_q == 2'h2) xtal_in <= ~xtal_in;
  end
endmodule : xtal_model
`default_nettype wire

// ---- cpu_clock_source_switcher_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_source_switcher_test;
  import clk_sw_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, xtal_in, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  osc_ctrl_t oc;
  int error_cnt, tests_run;
  cpu_clock_source_switcher #(.HIGH_START_CYC(16'h0014), .LOW_START_CYC(16'h001E)) cpu_clock_source_switcher_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .xtal_in(xtal_in), .osc_ctrl(oc));
  xtal_model xtal_model_i (.pclk(pclk), .run(oc.crystal_drive | oc.ext_clk_in), .xtal_in(xtal_in));
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  task automatic summarize;
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
    if (n >= 16) begin
      chk("pready", 32'h1, 32'h0);
      summarize();
    end
  endtask : xfer
  task automatic poll(input logic [11:0] a, input logic [7:0] w, input string s);
    int n;
    n = 0;
    do begin
      xfer(1'h0, a, 8'h00);
      n++;
    end while (q[7:0] !== w && n < 5000);
    chk(s, {24'h0, w}, q);
    if (n >= 5000) summarize();
  endtask : poll
  task automatic reset_vals;
    xfer(1'h0, 12'h008, 8'h00); chk("run", 32'hC0, q);
    xfer(1'h0, 12'h004, 8'h00); chk("stsel", 32'h07, q);
    xfer(1'h0, 12'h018, 8'h00); chk("unmapped", 32'h1, {31'h0, perr});
    xfer(1'h1, 12'h018, 8'hFF); chk("unmapped wr", 32'h1, {31'h0, perr});
  endtask : reset_vals
  task automatic mid_switch;
    xfer(1'h1, 12'h008, 8'hC2);
    xfer(1'h1, 12'h010, 8'h01);
    xfer(1'h0, 12'h010, 8'h00); chk("early sts", 32'h01, q);
    poll(12'h010, 8'h03, "onchip sts");
    xfer(1'h1, 12'h008, 8'hC3); chk("high run", 32'h0, {31'h0, oc.high_osc_run});
  endtask : mid_switch
  task automatic crystal;
    // Model runs near 21 MHz, so the gain bit goes high
    xfer(1'h1, 12'h000, 8'h41); chk("gain", 32'h1, {31'h0, oc.high_gain});
    xfer(1'h1, 12'h004, 8'h02);
    xfer(1'h1, 12'h008, 8'h43); chk("drive", 32'h1, {31'h0, oc.crystal_drive});
    poll(12'h00C, 8'hE0, "flags");
    xfer(1'h1, 12'h010, 8'h11);
    poll(12'h010, 8'h33, "main sts");
    chk("src sys", 32'(SRC_SYS), 32'(oc.active_src));
  endtask : crystal
  task automatic low_switch;
    xfer(1'h1, 12'h014, 8'h01); chk("low run", 32'h1, {31'h0, oc.low_osc_run});
    xfer(1'h1, 12'h010, 8'h51);
    poll(12'h010, 8'hF3, "cpu sts");
    chk("src low", 32'(SRC_LOW), 32'(oc.active_src));
    xfer(1'h1, 12'h010, 8'h41);
    xfer(1'h0, 12'h010, 8'h00); chk("main held", 32'hF3, q);
  endtask : low_switch
  task automatic halt_ext;
    xfer(1'h1, 12'h008, 8'hC3);
    xfer(1'h0, 12'h00C, 8'h00); chk("flags clr", 32'h0, q);
    xfer(1'h1, 12'h000, 8'hC0); chk("ext", 32'h1, {31'h0, oc.ext_clk_in});
    chk("no drive", 32'h0, {31'h0, oc.crystal_drive});
    chk("gain off", 32'h0, {31'h0, oc.high_gain});
  endtask : halt_ext
  task automatic high_restart;
    xfer(1'h1, 12'h008, 8'hC2); chk("high on", 32'h1, {31'h0, oc.high_osc_run});
    xfer(1'h1, 12'h010, 8'h50);
    xfer(1'h0, 12'h010, 8'h00); chk("high early", 32'hF2, q);
    poll(12'h010, 8'hF0, "high sts");
  endtask : high_restart
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    reset_vals();
    mid_switch();
    crystal();
    low_switch();
    halt_ext();
    high_restart();
    summarize();
  end
endmodule : cpu_clock_source_switcher_test
`default_nettype wire
